// ==== fp_bcd_pkg.sv ====
// Shared constants, field layouts and enumerations for the branch/compare/decode unit
package fp_bcd_pkg;
	// Software register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_FPSR     = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
	localparam logic [7:0] ADDR_DEC_INFO = 8'h10;
	localparam logic [7:0] ADDR_PC_INFO  = 8'h14;
	// Status word layout: cc[27:24] quotient[23:16] exception[15:8] accrued[7:0]
	localparam int CC_LSB   = 24;
	localparam int QUO_LSB  = 16;
	localparam int EXC_LSB  = 8;
	localparam int ACC_LSB  = 0;
	localparam int CC_N     = 3;
	localparam int CC_Z     = 2;
	localparam int CC_I     = 1;
	localparam int CC_NAN   = 0;
	localparam int EXC_UNORD = 7;   // Unordered-branch bit in exception byte
	localparam int ACC_IOP   = 7;   // Accrued invalid-operation bit
	localparam logic [31:0] FPSR_RST = 32'h0000_0000;
	// Interrupt event bits
	localparam int EV_BRANCH  = 0;
	localparam int EV_COMPARE = 1;
	localparam int EV_UNORD   = 2;
	localparam int EV_ILLEGAL = 3;
	localparam int EV_W       = 4;
	// Operation word fields
	localparam logic [3:0] LINE_F       = 4'hf;
	localparam logic [1:0] BRANCH_PAT   = 2'b01;
	localparam logic [2:0] GENERAL_PAT  = 3'b000;
	localparam logic [6:0] OPM_COMPARE  = 7'h38;
	localparam logic [6:0] OPM_HATAN    = 7'h0d;
	// Source format codes
	localparam logic [2:0] FMT_L = 3'b000;
	localparam logic [2:0] FMT_S = 3'b001;
	localparam logic [2:0] FMT_X = 3'b010;
	localparam logic [2:0] FMT_P = 3'b011;
	localparam logic [2:0] FMT_W = 3'b100;
	localparam logic [2:0] FMT_D = 3'b101;
	localparam logic [2:0] FMT_B = 3'b110;
	// Effective-address modes and mode-7 register sub-codes
	localparam logic [2:0] EAM_DREG  = 3'b000;
	localparam logic [2:0] EAM_AREG  = 3'b001;
	localparam logic [2:0] EAM_IND   = 3'b010;
	localparam logic [2:0] EAM_POST  = 3'b011;
	localparam logic [2:0] EAM_PRE   = 3'b100;
	localparam logic [2:0] EAM_DISP  = 3'b101;
	localparam logic [2:0] EAM_INDEX = 3'b110;
	localparam logic [2:0] EAM_EXT   = 3'b111;
	localparam logic [2:0] EXT_ABSW  = 3'b000;
	localparam logic [2:0] EXT_ABSL  = 3'b001;
	localparam logic [2:0] EXT_PCD   = 3'b010;
	localparam logic [2:0] EXT_PCX   = 3'b011;
	localparam logic [2:0] EXT_IMM   = 3'b100;
	localparam logic [31:0] PC_BASE_OFS = 32'h0000_0002;
	// Exponent biases
	localparam logic [14:0] EXT_BIAS = 15'h3fff;
	localparam logic [14:0] SGL_BIAS = 15'h007f;
	localparam logic [14:0] DBL_BIAS = 15'h03ff;
	localparam logic [14:0] EXP_MAX  = 15'h7fff;
	localparam logic [14:0] INT_EXP  = 15'h401e;  // Bias plus 31
	// Decoded addressing class
	typedef enum logic [3:0] {EA_NONE, EA_DATA_REG, EA_INDIRECT, EA_POSTINC, EA_PREDEC,
		EA_DISP, EA_INDEXED, EA_ABS_SHORT, EA_ABS_LONG, EA_IMMEDIATE, EA_PC_DISP,
		EA_PC_INDEXED, EA_INVALID} ea_class_e;
endpackage

// ==== fp_branch_compare_decode.sv ====
// Branch, compare and general-format decode logic of the floating-point coprocessor
`timescale 1ns/1ps

// What this block does
// - R/M 0 register source, 1 memory source
// - Address field ignored for register source
// - Three-bit specifier picks the source format
// - Data register only for small formats; never address
// - Decode address modes and mode-7 sub-modes
// - Equal register fields read and write one register
// - True condition loads PC with base plus displacement
// - Branch base is operation word address plus two
// - Size 0 sign-extended word, 1 long high first
// - Predicate picks one of 32 condition tests
// - NaN with nonaware test sets unordered flag
// - Unordered sets exception unordered and accrued invalid bits, nothing else changes
// - Unordered trap recurs until cause cleared
// - Compare converts source, subtracts from destination
// - Compare writes no register, only condition codes
// - Compare always clears the infinity bit
// - Compare sets fixed and result bits, clears rest
module fp_branch_compare_decode
	import fp_bcd_pkg::*;
(
	input  wire logic        CLK,         // Processor clock
	input  wire logic        RST,         // Synchronous reset, active high
	input  wire logic        ISSUE,       // Instruction issue strobe
	input  wire logic [15:0] OP_WORD,     // Operation word
	input  wire logic [15:0] CMD_WORD,    // Command word of general format
	input  wire logic [15:0] EXT_HI,      // First extension word
	input  wire logic [15:0] EXT_LO,      // Second extension word
	input  wire logic [31:0] OP_ADDR,     // Address of the operation word
	input  wire logic [79:0] SRC_DATA,    // Source operand, right aligned
	input  wire logic [79:0] DST_DATA,    // Destination register value
	input  wire logic [7:0]  ADDR,        // Register byte address
	input  wire logic [31:0] WDATA,       // Register write data
	input  wire logic        WR,          // Register write strobe
	input  wire logic        RD,          // Register read strobe
	output logic      [31:0] RDATA,       // Register read data
	output logic             DONE,        // Instruction finished pulse
	output logic             BR_TAKEN,    // Branch taken pulse
	output logic      [31:0] NEXT_PC,     // Program counter after branch
	output logic             PRE_EXC,     // Pre-instruction exception pulse
	output logic             ILLEGAL,     // Illegal encoding pulse
	output logic             EA_USED,     // Source from effective address
	output logic      [3:0]  EA_CLASS,    // Decoded addressing class
	output logic      [2:0]  EA_REG,      // Address or data register number
	output logic      [2:0]  SRC_FMT,     // Source format when EA used
	output logic      [2:0]  RD_REG,      // Floating register read: source, or destination for memory sources
	output logic      [2:0]  DST_REG,     // Destination floating register
	output logic             WB_EN,       // Result written to destination
	output logic             IRQ          // Level interrupt
);

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Classify an extended value: {nan, inf, zero}
	function automatic logic [2:0] classify(input logic [79:0] v);
		logic inf_nan;
		inf_nan = (v[78:64] == EXP_MAX);
		classify = {inf_nan && (v[62:0] != '0), inf_nan && (v[62:0] == '0),
			(v[78:64] == '0) && (v[63:0] == '0)};
	endfunction

	// Convert a source of any supported format to extended precision
	function automatic logic [79:0] to_ext(input logic [2:0] fmt, input logic [79:0] d);
		logic [31:0] ival;
		logic [31:0] mag;
		logic        sgn;
		int          lz;
		to_ext = '0;
		ival = d[31:0];
		lz = 0;
		case (fmt)
			FMT_W: ival = {{16{d[15]}}, d[15:0]};
			FMT_B: ival = {{24{d[7]}}, d[7:0]};
			default: ival = d[31:0];
		endcase
		sgn = ival[31];
		mag = sgn ? (~ival + 32'h0000_0001) : ival;
		case (fmt)
			FMT_L, FMT_W, FMT_B: begin
				for (int i = 0; i < 32; i++) begin
					if (mag[31 - i] == 1'b0 && lz == i) begin
						lz = i + 1;
					end
				end
				if (mag != '0) begin
					to_ext = {sgn, INT_EXP - 15'(lz), mag << lz, 32'h0000_0000};
				end
			end
			FMT_S: begin
				if (d[30:23] == 8'hff) begin
					to_ext = {d[31], EXP_MAX, 1'b0, d[22:0], 40'h00_0000_0000};
				end else if (d[30:23] != 8'h00) begin
					to_ext = {d[31], 15'(d[30:23]) + EXT_BIAS - SGL_BIAS, 1'b1, d[22:0],
						40'h00_0000_0000};
				end else begin
					to_ext = {d[31], 15'h0000, 64'h0};
				end
			end
			FMT_D: begin
				if (d[62:52] == 11'h7ff) begin
					to_ext = {d[63], EXP_MAX, 1'b0, d[51:0], 11'h000};
				end else if (d[62:52] != 11'h000) begin
					to_ext = {d[63], 15'(d[62:52]) + EXT_BIAS - DBL_BIAS, 1'b1, d[51:0],
						11'h000};
				end else begin
					to_ext = {d[63], 15'h0000, 64'h0};
				end
			end
			default: to_ext = d;
		endcase
	endfunction

	// Evaluate one of the 32 condition tests on {N,Z,I,NaN}
	function automatic logic cond_true(input logic [4:0] p, input logic [3:0] cc);
		logic n;
		logic z;
		logic u;
		n = cc[CC_N];
		z = cc[CC_Z];
		u = cc[CC_NAN];
		case (p[3:0])
			4'h0: cond_true = 1'b0;
			4'h1: cond_true = z;
			4'h2: cond_true = ~(u | z | n);
			4'h3: cond_true = z | ~(u | n);
			4'h4: cond_true = n & ~(u | z);
			4'h5: cond_true = z | (n & ~u);
			4'h6: cond_true = ~(u | z);
			4'h7: cond_true = ~u;
			4'h8: cond_true = u;
			4'h9: cond_true = u | z;
			4'ha: cond_true = u | ~(n | z);
			4'hb: cond_true = u | ~n | z;
			4'hc: cond_true = u | (n & ~z);
			4'hd: cond_true = u | z | n;
			4'he: cond_true = ~z;
			default: cond_true = 1'b1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Instruction decode

	logic        is_branch;
	logic        is_general;
	logic        rm;
	logic [2:0]  mode;
	logic [2:0]  ea_reg;
	logic [2:0]  fmt;
	ea_class_e   ea_cls;
	logic        small_fmt;
	logic        is_compare;
	logic [31:0] disp;
	logic [31:0] target;
	logic        pred_true;
	logic        unord;
	logic        trap_en_ff;

	assign is_branch  = (OP_WORD[15:12] == LINE_F) && (OP_WORD[8:7] == BRANCH_PAT);
	assign is_general = (OP_WORD[15:12] == LINE_F) && (OP_WORD[8:6] == GENERAL_PAT);
	assign rm         = CMD_WORD[14];
	assign mode       = OP_WORD[5:3];
	assign ea_reg     = OP_WORD[2:0];
	assign fmt        = CMD_WORD[12:10];
	assign small_fmt  = (fmt == FMT_B) || (fmt == FMT_W) || (fmt == FMT_L) || (fmt == FMT_S);
	assign is_compare = (CMD_WORD[6:0] == OPM_COMPARE);

	// Addressing class; the field is not looked at for register sources
	always_comb begin
		ea_cls = EA_INVALID;
		if (!rm) begin
			ea_cls = EA_NONE;
		end else begin
			case (mode)
				EAM_DREG:  ea_cls = small_fmt ? EA_DATA_REG : EA_INVALID;
				EAM_AREG:  ea_cls = EA_INVALID;
				EAM_IND:   ea_cls = EA_INDIRECT;
				EAM_POST:  ea_cls = EA_POSTINC;
				EAM_PRE:   ea_cls = EA_PREDEC;
				EAM_DISP:  ea_cls = EA_DISP;
				EAM_INDEX: ea_cls = EA_INDEXED;
				EAM_EXT: begin
					case (ea_reg)
						EXT_ABSW: ea_cls = EA_ABS_SHORT;
						EXT_ABSL: ea_cls = EA_ABS_LONG;
						EXT_IMM:  ea_cls = EA_IMMEDIATE;
						EXT_PCD:  ea_cls = EA_PC_DISP;
						EXT_PCX:  ea_cls = EA_PC_INDEXED;
						default:  ea_cls = EA_INVALID;
					endcase
				end
				default: ea_cls = EA_INVALID;
			endcase
			if (fmt == FMT_P || fmt == 3'b111) begin
				ea_cls = EA_INVALID;
			end
		end
	end

	// Branch displacement, target and condition
	assign disp = OP_WORD[6] ? {EXT_HI, EXT_LO} : {{16{EXT_HI[15]}}, EXT_HI};
	assign target = OP_ADDR + PC_BASE_OFS + disp;
	logic [31:0] fpsr_ff;
	assign pred_true = cond_true(OP_WORD[4:0], fpsr_ff[CC_LSB +: 4]);
	assign unord = fpsr_ff[CC_LSB + CC_NAN] && OP_WORD[4];

	////////////////////////////////////////////////////////////////////////////
	// Compare datapath

	logic [79:0] src_x;
	logic [2:0]  scls;
	logic [2:0]  dcls;
	logic        mag_lt;
	logic        mag_eq;
	logic        is_eq;
	logic        is_lt;
	logic [3:0]  cmp_cc;

	assign src_x  = rm ? to_ext(fmt, SRC_DATA) : SRC_DATA;
	assign scls   = classify(src_x);
	assign dcls   = classify(DST_DATA);
	assign mag_lt = DST_DATA[78:0] < src_x[78:0];
	assign mag_eq = DST_DATA[78:0] == src_x[78:0];

	// Signed ordering of destination minus source
	always_comb begin
		is_eq = (dcls[0] && scls[0]) || (mag_eq && DST_DATA[79] == src_x[79]);
		if (DST_DATA[79] != src_x[79]) begin
			is_lt = DST_DATA[79] && !is_eq;
		end else begin
			is_lt = DST_DATA[79] ? (!mag_lt && !mag_eq) : mag_lt;
		end
		cmp_cc = '0;
		if (dcls[2] || scls[2]) begin
			cmp_cc[CC_NAN] = 1'b1;
		end else begin
			cmp_cc[CC_Z] = is_eq;
			// A negative zero or infinity destination also sets N against an equal operand
			cmp_cc[CC_N] = is_lt || (DST_DATA[79] && is_eq && (dcls[0] || dcls[1]));
		end
		cmp_cc[CC_I] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Execution outputs, all registered

	logic illegal_now;
	assign illegal_now = ISSUE && !(is_branch && !OP_WORD[5]) &&
		!(is_general && !CMD_WORD[15] && !CMD_WORD[13] && ea_cls != EA_INVALID);

	// One-cycle pulses of each issued instruction, and NEXT_PC held from the last untrapped branch
	always_ff @(posedge CLK) begin
		if (RST) begin
			DONE     <= 1'b0;
			BR_TAKEN <= 1'b0;
			NEXT_PC  <= '0;
			PRE_EXC  <= 1'b0;
			ILLEGAL  <= 1'b0;
		end else begin
			DONE     <= ISSUE && !illegal_now;
			ILLEGAL  <= illegal_now;
			PRE_EXC  <= ISSUE && is_branch && !illegal_now && unord && trap_en_ff;
			BR_TAKEN <= ISSUE && is_branch && !illegal_now && pred_true &&
				!(unord && trap_en_ff);
			if (ISSUE && is_branch && !illegal_now && !(unord && trap_en_ff)) begin
				NEXT_PC <= pred_true ? target : OP_ADDR + PC_BASE_OFS +
					(OP_WORD[6] ? 32'h0000_0004 : 32'h0000_0002);
			end
		end
	end

	// Decoded operand fields of general instructions
	always_ff @(posedge CLK) begin
		if (RST) begin
			EA_USED  <= 1'b0;
			EA_CLASS <= '0;
			EA_REG   <= '0;
			SRC_FMT  <= '0;
			RD_REG   <= '0;
			DST_REG  <= '0;
			WB_EN    <= 1'b0;
		end else if (ISSUE && is_general) begin
			EA_USED  <= rm;
			EA_CLASS <= ea_cls;
			EA_REG   <= rm ? ea_reg : 3'b000;
			SRC_FMT  <= rm ? fmt : FMT_X;
			RD_REG   <= rm ? CMD_WORD[9:7] : CMD_WORD[12:10];
			DST_REG  <= CMD_WORD[9:7];
			WB_EN    <= !is_compare && !illegal_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers and status

	logic [EV_W-1:0] int_stat_ff;
	logic [EV_W-1:0] int_mask_ff;
	logic [EV_W-1:0] events;
	logic [31:0]     nxt_fpsr;

	assign events[EV_BRANCH]  = ISSUE && is_branch && !illegal_now;
	assign events[EV_COMPARE] = ISSUE && is_general && is_compare && !illegal_now;
	assign events[EV_UNORD]   = events[EV_BRANCH] && unord;
	assign events[EV_ILLEGAL] = illegal_now;

	// Status word: software write first, instruction effects on top
	always_comb begin
		nxt_fpsr = fpsr_ff;
		if (WR && ADDR == ADDR_FPSR) begin
			nxt_fpsr = WDATA;
		end
		if (events[EV_UNORD]) begin
			nxt_fpsr[EXC_LSB + EXC_UNORD] = 1'b1;
			nxt_fpsr[ACC_LSB + ACC_IOP]   = 1'b1;
		end
		if (events[EV_COMPARE]) begin
			nxt_fpsr[CC_LSB +: 4] = cmp_cc;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			fpsr_ff <= FPSR_RST;
		end else begin
			fpsr_ff <= nxt_fpsr;
		end
	end

	// Control, mask and sticky interrupt status; set beats clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			trap_en_ff  <= 1'b0;
			int_mask_ff <= '0;
			int_stat_ff <= '0;
		end else begin
			if (WR && ADDR == ADDR_CTRL) begin
				trap_en_ff <= WDATA[0];
			end
			if (WR && ADDR == ADDR_INT_MASK) begin
				int_mask_ff <= WDATA[EV_W-1:0];
			end
			int_stat_ff <= (int_stat_ff & ~((WR && ADDR == ADDR_INT_STAT) ?
				WDATA[EV_W-1:0] : '0)) | events;
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= '0;
			IRQ   <= 1'b0;
		end else begin
			IRQ   <= |(int_stat_ff & int_mask_ff);
			RDATA <= '0;
			if (RD) begin
				case (ADDR)
					ADDR_CTRL:     RDATA <= {31'h0, trap_en_ff};
					ADDR_FPSR:     RDATA <= fpsr_ff;
					ADDR_INT_STAT: RDATA <= {28'h0, int_stat_ff};
					ADDR_INT_MASK: RDATA <= {28'h0, int_mask_ff};
					ADDR_DEC_INFO: RDATA <= {13'h0, WB_EN, DST_REG, RD_REG, SRC_FMT,
						EA_REG, 1'b0, EA_CLASS, EA_USED};
					ADDR_PC_INFO:  RDATA <= NEXT_PC;
					default:       RDATA <= '0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	chk_unord_sets_iop: assert property (@(posedge CLK) disable iff (RST)
		events[EV_UNORD] |=> fpsr_ff[EXC_LSB + EXC_UNORD] && fpsr_ff[ACC_LSB + ACC_IOP])
		else $error("unordered branch did not set both flags");
	chk_branch_target: assert property (@(posedge CLK) disable iff (RST)
		(ISSUE && is_branch && !illegal_now && pred_true && !trap_en_ff)
		|=> BR_TAKEN && NEXT_PC == $past(OP_ADDR) + 32'h2 + $past(disp))
		else $error("branch target wrong");
	chk_word_disp: assert property (@(posedge CLK) disable iff (RST)
		(ISSUE && is_branch && !OP_WORD[6]) |-> disp[31:16] == {16{EXT_HI[15]}})
		else $error("word displacement not sign extended");
	chk_cmp_no_inf: assert property (@(posedge CLK) disable iff (RST)
		events[EV_COMPARE] |=> !fpsr_ff[CC_LSB + CC_I])
		else $error("compare left infinity bit set");
	chk_cmp_no_write: assert property (@(posedge CLK) disable iff (RST)
		(ISSUE && is_general && is_compare) |=> !WB_EN)
		else $error("compare enabled a write back");
	chk_areg_refused: assert property (@(posedge CLK) disable iff (RST)
		(ISSUE && is_general && rm && mode == EAM_AREG) |=> ILLEGAL && !DONE)
		else $error("address register source accepted");
	chk_same_reg: assert property (@(posedge CLK) disable iff (RST)
		(ISSUE && is_general && !rm && CMD_WORD[12:10] == CMD_WORD[9:7])
		|=> RD_REG == DST_REG)
		else $error("single register form split");
	chk_trap_no_branch: assert property (@(posedge CLK) disable iff (RST)
		PRE_EXC |-> !BR_TAKEN && $past(fpsr_ff[CC_LSB + CC_NAN]))
		else $error("trap raised without cause");
	chk_cmp_equal: assert property (@(posedge CLK) disable iff (RST)
		(events[EV_COMPARE] && !dcls[2] && !scls[2] && DST_DATA == src_x)
		|=> fpsr_ff[CC_LSB + CC_Z])
		else $error("equal operands did not set zero bit");
	chk_reg_src_ignores_ea: assert property (@(posedge CLK) disable iff (RST)
		(ISSUE && is_general && !rm) |=> !EA_USED && EA_CLASS == 4'(EA_NONE))
		else $error("register source decoded an address");

endmodule

// ==== cpu_issue_model.sv ====
// Model of the integer processor that issues coprocessor instructions
`timescale 1ns/1ps
module cpu_issue_model (
	input  wire logic        clk,      // Processor clock
	output logic             issue,    // Issue strobe
	output logic      [15:0] op_word,  // Operation word
	output logic      [15:0] cmd_word, // Command word
	output logic      [15:0] ext_hi,   // First extension word
	output logic      [15:0] ext_lo,   // Second extension word
	output logic      [31:0] op_addr,  // Operation word address
	output logic      [79:0] src_data, // Source operand
	output logic      [79:0] dst_data  // Destination operand
);
	// Idle values before the first issue
	initial begin
		issue = 1'b0;
		{op_word, cmd_word, ext_hi, ext_lo, op_addr} = '0;
		{src_data, dst_data} = '0;
	end
	// One issue cycle; afterwards the fields turn to junk so stale values are never trusted
	task automatic send(input logic [15:0] op, input logic [15:0] cmd, input logic [31:0] disp,
		input logic [31:0] addr, input logic [79:0] src, input logic [79:0] dst);
		@(posedge clk);
		issue    <= 1'b1;
		op_word  <= op;
		cmd_word <= cmd;
		{ext_hi, ext_lo} <= disp; // Long displacement, high word first
		op_addr  <= addr;
		src_data <= src;
		dst_data <= dst;
		@(posedge clk);
		issue    <= 1'b0;
		{op_word, cmd_word, ext_hi, ext_lo} <= ~{op, cmd, disp};
		{op_addr, src_data, dst_data} <= ~{addr, src, dst};
	endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the branch, compare and decode unit
`timescale 1ns/1ps
module tb_top;
	import fp_bcd_pkg::*;
	logic        clk, rst, issue, wr, rd, done, br_taken, pre_exc, illegal, ea_used, wb_en, irq;
	logic [15:0] op_word, cmd_word, ext_hi, ext_lo;
	logic [31:0] op_addr, wdata, rdata, next_pc, v, r, d, base, exp_pc, disp;
	logic [79:0] src_data, dst_data;
	logic [7:0]  addr;
	logic [3:0]  ea_class, cc;
	logic [2:0]  ea_reg, src_fmt, rd_reg, dst_reg;
	logic [4:0]  p;
	logic        t;
	int          n_errors, num_checks;
	logic [31:0] seed = 32'ha76c;
	// Decode cases: mode, register, format, class (12 means refused)
	localparam logic [12:0] DEC_TAB [15] = '{13'h02e1, 13'h00ac, 13'h050c, 13'h0982,
		13'h0e13, 13'h12c4, 13'h1755, 13'h1ba6, 13'h1c67, 13'h1c88, 13'h1e19, 13'h1d5a,
		13'h1dcb, 13'h1e8c, 13'h083c};
	localparam logic [79:0] ONE = {16'h3fff, 64'h8000_0000_0000_0000};
	localparam logic [79:0] TWO = {16'h4000, 64'h8000_0000_0000_0000};
	localparam logic [79:0] INF = {16'h7fff, 64'h0};
	localparam logic [79:0] NEG = {1'b1, 79'h0};
	localparam logic [79:0] CMP_D [9] = '{ONE, TWO, ONE, 80'h0, NEG, INF | NEG, INF, ONE | NEG,
		NEG};
	localparam logic [79:0] CMP_S [9] = '{TWO, ONE, ONE, NEG, 80'h0, INF, INF, ONE, ONE | NEG};
	localparam logic [3:0]  CMP_CC [9] = '{4'h8, 4'h0, 4'h4, 4'h4, 4'hc, 4'h8, 4'h4, 4'h8,
		4'h0};

	////////////////////////////////////////////////////////////////////////////////
	// Clock and instances
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	fp_branch_compare_decode fp_branch_compare_decode_inst (.CLK(clk), .RST(rst),
		.ISSUE(issue), .OP_WORD(op_word), .CMD_WORD(cmd_word), .EXT_HI(ext_hi),
		.EXT_LO(ext_lo), .OP_ADDR(op_addr), .SRC_DATA(src_data), .DST_DATA(dst_data),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DONE(done),
		.BR_TAKEN(br_taken), .NEXT_PC(next_pc), .PRE_EXC(pre_exc), .ILLEGAL(illegal),
		.EA_USED(ea_used), .EA_CLASS(ea_class), .EA_REG(ea_reg), .SRC_FMT(src_fmt),
		.RD_REG(rd_reg), .DST_REG(dst_reg), .WB_EN(wb_en), .IRQ(irq));
	cpu_issue_model cpu_issue_model_inst (.clk(clk), .issue(issue), .op_word(op_word),
		.cmd_word(cmd_word), .ext_hi(ext_hi), .ext_lo(ext_lo), .op_addr(op_addr),
		.src_data(src_data), .dst_data(dst_data));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Condition test from N, Z, NaN codes
	function automatic logic pred(input logic [4:0] q, input logic [3:0] c);
		logic n, z, u;
		{n, z, u} = {c[3], c[2], c[0]};
		case (q[3:0])
			4'h0: return 1'b0;
			4'h1: return z;
			4'h2: return !(u | z | n);
			4'h3: return z | !(u | n);
			4'h4: return n & !(u | z);
			4'h5: return z | (n & !u);
			4'h6: return !(u | z);
			4'h7: return !u;
			4'h8: return u;
			4'h9: return u | z;
			4'ha: return u | !(n | z);
			4'hb: return u | z | !n;
			4'hc: return u | (n & !z);
			4'hd: return u | z | n;
			4'he: return !z;
			default: return 1'b1;
		endcase
	endfunction
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string w);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string w);
		chk_val({31'h0, got}, {31'h0, exp}, w);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge clk);
		{addr, wdata, wr} <= {a, dv, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] dv);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		#1 dv = rdata;
	endtask
	task automatic iss(input logic [15:0] op, input logic [15:0] cmd, input logic [31:0] dp,
		input logic [31:0] a, input logic [79:0] s, input logic [79:0] dd);
		cpu_issue_model_inst.send(op, cmd, dp, a, s, dd);
		#1;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Guard against a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("unexpected at %0t: run limit reached", $time);
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst, addr, wdata, wr, rd} = {1'b1, 42'h0};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		reg_rd(ADDR_FPSR, v);
		chk_val(v, FPSR_RST, "fpsr reset");
		reg_wr(8'h20, 32'hffff_ffff);
		reg_rd(8'h20, v);
		chk_val(v, 32'h0, "unmapped");
		$display("reset test done");
		// Random branches, first few forced unordered
		for (int i = 0; i < 40; i++) begin
			r = xs();
			d = xs();
			cc = (i < 4) ? 4'h1 : r[3:0];
			p = (i < 4) ? {1'b1, r[7:4]} : r[8:4];
			base = {15'h0, r[31:16], 1'b0};
			reg_wr(ADDR_FPSR, {4'h0, cc, r[23:16], 8'h0, 1'b0, r[14:8]});
			iss({LINE_F, r[12:10], BRANCH_PAT, r[9], 1'b0, p}, 16'h0, d, base, '0, '0);
			t = pred(p, cc);
			disp = r[9] ? d : {{16{d[31]}}, d[31:16]};
			exp_pc = t ? base + PC_BASE_OFS + disp : base + (r[9] ? 32'h6 : 32'h4);
			chk_bit(done, 1'b1, "branch done");
			chk_bit(br_taken, t, "taken");
			chk_val(next_pc, exp_pc, "target");
			reg_rd(ADDR_FPSR, v);
			chk_val(v, {4'h0, cc, r[23:16], 8'h0, 1'b0, r[14:8]}
				| ((cc[0] & p[4]) ? 32'h8080 : 32'h0), "branch status");
		end
		$display("branch test done");
		// Trap repeats until the NaN code is cleared
		reg_wr(ADDR_CTRL, 32'h1);
		reg_wr(ADDR_FPSR, 32'h0100_0000);
		for (int i = 0; i < 3; i++) begin
			if (i == 2) reg_wr(ADDR_FPSR, 32'h0400_0000);
			iss(16'hf291, 16'h0, 32'h0010_0000, 32'h200, '0, '0); // Retried as handler returns
			chk_bit(pre_exc, i < 2, "trap");
			chk_bit(br_taken, i == 2, "trap taken");
			chk_val(next_pc, (i < 2) ? exp_pc : 32'h212, "trap pc");
		end
		reg_rd(ADDR_PC_INFO, v);
		chk_val(v, 32'h212, "pc reg");
		iss(16'hf2a1, 16'h0, 32'h0, 32'h300, '0, '0);
		chk_bit(illegal, 1'b1, "bad predicate");
		chk_bit(done, 1'b0, "bad done");
		$display("trap test done");
		// Interrupt raise, mask, clear
		reg_rd(ADDR_INT_STAT, v);
		chk_val(v, 32'hd, "int status");
		chk_bit(irq, 1'b0, "masked");
		reg_wr(ADDR_INT_MASK, 32'h8);
		@(posedge clk);
		#1 chk_bit(irq, 1'b1, "irq on");
		reg_wr(ADDR_INT_STAT, 32'hf);
		@(posedge clk);
		#1 chk_bit(irq, 1'b0, "irq off");
		$display("interrupt test done");
		// Address modes and formats
		foreach (DEC_TAB[i]) begin
			r = xs();
			iss({LINE_F, 3'b001, GENERAL_PAT, DEC_TAB[i][12:7]},
				{3'b010, DEC_TAB[i][6:4], r[2:0], OPM_COMPARE}, '0, '0, ONE, ONE);
			chk_bit(illegal, DEC_TAB[i][3:0] == 4'hc, "refused");
			chk_bit(wb_en, 1'b0, "no write");
			if (DEC_TAB[i][3:0] != 4'hc) begin
				chk_val({ea_used, ea_class, ea_reg, src_fmt, dst_reg},
					{1'b1, DEC_TAB[i][3:0], DEC_TAB[i][9:4], r[2:0]}, "decode");
			end
		end
		iss({LINE_F, 3'b001, GENERAL_PAT, 6'h3d}, {3'b000, 3'd3, 3'd3, OPM_COMPARE}, '0, '0,
			ONE, ONE);
		chk_bit(illegal, 1'b0, "reg source");
		chk_val({ea_used, rd_reg, dst_reg, wb_en}, {1'b0, 3'd3, 3'd3, 1'b0}, "reg pair");
		// Non-compare operation writes its single register back
		iss({LINE_F, 3'b001, GENERAL_PAT, 6'h0}, {3'b000, 3'd4, 3'd4, OPM_HATAN}, '0, '0,
			ONE, ONE);
		chk_val({rd_reg, dst_reg, wb_en}, {3'd4, 3'd4, 1'b1}, "write back");
		reg_rd(ADDR_DEC_INFO, v);
		chk_val(v, {13'h0, 1'b1, 3'd4, 3'd4, FMT_X, 3'd0, 1'b0, 4'h0, 1'b0},
			"decode info");
		$display("decode test done");
		// Compare codes over operand classes
		foreach (CMP_CC[i]) begin
			reg_wr(ADDR_FPSR, 32'h0255_0000);
			iss({LINE_F, 3'b001, GENERAL_PAT, 6'h0}, {3'b000, 3'd1, 3'd2, OPM_COMPARE}, '0, '0,
				CMP_S[i], CMP_D[i]);
			chk_bit(wb_en, 1'b0, "cmp no write");
			reg_rd(ADDR_FPSR, v);
			chk_val(v, {4'h0, CMP_CC[i], 24'h55_0000}, "cmp codes");
		end
		// Word integer source from a data register, converted before the compare
		reg_wr(ADDR_FPSR, 32'h0255_0000);
		iss({LINE_F, 3'b001, GENERAL_PAT, EAM_DREG, 3'b000}, {3'b010, FMT_W, 3'd2, OPM_COMPARE},
			'0, '0, 80'h2, TWO);
		reg_rd(ADDR_FPSR, v);
		chk_val(v, 32'h0455_0000, "converted compare");
		$display("compare test done");
		complete_run();
	end
endmodule
